// ### design/conv_out_ctrl.sv
// Converter digital back end: powerdown hold, output coding, data word
// How it works
// - While low_power_hold is high the block sits in powerdown and converts nothing.
// - In powerdown the data word is meaningless and data_valid is held low.
// - Entering powerdown flushes every sample in the pipeline and buffer.
// - Hold acts as a level every cycle, so no clock rate or count is assumed.
// - With output_format_select high the word is two's complement.
// - With output_format_select low the word is offset binary.
// - Each sample leaves as one parallel ten-bit word.
// - With sink_ready high a new word appears every cycle, a fixed latency after its sample, until a sink stall adds buffer delay.
// - Offset binary mid-scale lies between 0x1ff and 0x200.
`timescale 1ns/1ps
`default_nettype none
module conv_out_ctrl
  import conv_out_pkg::*;
#(
  parameter int LATENCY = PIPE_LAT,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic low_power_hold,
  input wire logic output_format_select,
  input wire logic [conv_out_pkg::DATA_W-1:0] sample_code,
  output logic [conv_out_pkg::DATA_W-1:0] data_out,
  output logic data_valid,
  output logic powered_down,
  input wire logic sink_ready,
  output logic overflow
);
  import conv_out_pkg::*;

  pwr_state_t state_r;
  pwr_state_t state_nxt;
  sample_t pipe_r [LATENCY];
  logic [$clog2(LATENCY+1)-1:0] fill_r;
  logic fifo_in_ready;
  logic fifo_out_valid;
  sample_t fifo_out;
  sample_t head;
  logic pop;

  // Power state: hold pin wins over everything
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: if (low_power_hold) state_nxt = ST_DOWN;
      ST_DOWN: if (!low_power_hold) state_nxt = ST_REFILL;
      ST_REFILL: begin
        if (low_power_hold) begin
          state_nxt = ST_DOWN;
        end else if (fill_r == ($clog2(LATENCY+1))'(LATENCY)) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_DOWN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_DOWN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Refill counter; samples older than the pipe are not trustworthy
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fill_r <= '0;
    end else if (low_power_hold || state_r != ST_REFILL) begin
      fill_r <= '0;
    end else if (fill_r != ($clog2(LATENCY+1))'(LATENCY)) begin
      fill_r <= fill_r + 1'b1;
    end
  end

  // fixed-latency pipe, one sample per cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe_r[i] <= '0;
      end
    end else begin
      pipe_r[0].good <= !low_power_hold;
      pipe_r[0].code <= sample_code;
      for (int i = 1; i < LATENCY; i++) begin
        pipe_r[i].good <= pipe_r[i-1].good && !low_power_hold;
        pipe_r[i].code <= pipe_r[i-1].code;
      end
    end
  end

  // Buffer absorbs short sink stalls; samples drop only when it is full
  sample_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .flush(low_power_hold),
    .in_valid(pipe_r[LATENCY-1].good),
    .in_ready(fifo_in_ready),
    .in_data(pipe_r[LATENCY-1]),
    .out_valid(fifo_out_valid),
    .out_ready(sink_ready),
    .out_data(fifo_out)
  );

  assign head = fifo_out;
  assign pop = fifo_out_valid && sink_ready && !low_power_hold;

  // offset binary passes the code as converted
  // offset code passes unshifted across mid-scale
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_out <= DATA_RST;
    end else if (pop) begin
      data_out <= output_format_select ? (head.code ^ SIGN_FLIP) : head.code;
    end
  end

  // hold pin gates valid without waiting on state
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_valid <= 1'b0;
      powered_down <= 1'b1;
    end else begin
      data_valid <= pop;
      powered_down <= low_power_hold || state_nxt != ST_RUN;
    end
  end

  // Sticky drop flag; the sink must keep up in steady state
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      overflow <= 1'b0;
    end else if (pipe_r[LATENCY-1].good && !fifo_in_ready) begin
      overflow <= 1'b1;
    end
  end

  property p_hold_quiet;
    @(posedge sys_clk) disable iff (!arst_n)
      low_power_hold |=> !data_valid && powered_down;
  endproperty
  a_hold_quiet: assert property (p_hold_quiet)
    else $error("valid seen while held in powerdown");

  // no word for the latency after release
  property p_flush;
    @(posedge sys_clk) disable iff (!arst_n)
      $fell(low_power_hold) |-> !data_valid [*6];
  endproperty
  a_flush: assert property (p_flush)
    else $error("stale sample delivered after powerdown");

  property p_twos;
    @(posedge sys_clk) disable iff (!arst_n)
      pop && output_format_select |=> data_out == ($past(head.code) ^ SIGN_FLIP);
  endproperty
  a_twos: assert property (p_twos)
    else $error("two's complement coding wrong");

  property p_offs;
    @(posedge sys_clk) disable iff (!arst_n)
      pop && !output_format_select |=> data_out == $past(head.code);
  endproperty
  a_offs: assert property (p_offs)
    else $error("offset binary coding wrong");

  // upper mid-scale code maps to zero across the sign bit
  property p_mid;
    @(posedge sys_clk) disable iff (!arst_n)
      pop && output_format_select && head.code == MID_HIGH |=> data_out == 10'h000;
  endproperty
  a_mid: assert property (p_mid)
    else $error("mid-scale code not at zero");

  // steady stream, valid each cycle when sink ready
  property p_stream;
    @(posedge sys_clk) disable iff (!arst_n)
      (!low_power_hold && sink_ready && arst_n) [*8] |=> data_valid;
  endproperty
  a_stream: assert property (p_stream)
    else $error("word missing in steady stream");

  property p_pd;
    @(posedge sys_clk) disable iff (!arst_n)
      state_r == ST_RUN && !low_power_hold |=> !powered_down || low_power_hold;
  endproperty
  a_pd: assert property (p_pd)
    else $error("powerdown flag raised while running");

  property p_word;
    @(posedge sys_clk) disable iff (!arst_n)
      !data_valid && !$past(pop) |-> $stable(data_out);
  endproperty
  a_word: assert property (p_word)
    else $error("data word moved without a sample");

  // status stays down while the pipe refills
  property p_refill;
    @(posedge sys_clk) disable iff (!arst_n)
      $fell(low_power_hold) |-> powered_down [*8];
  endproperty
  a_refill: assert property (p_refill)
    else $error("powerdown status dropped before the pipe refilled");

  // offset binary low mid-scale code keeps its sign bit clear
  property p_mid_low;
    @(posedge sys_clk) disable iff (!arst_n)
      pop && !output_format_select && head.code == MID_LOW |=> data_out == MID_LOW;
  endproperty
  a_mid_low: assert property (p_mid_low)
    else $error("offset binary mid-scale code altered");
endmodule : conv_out_ctrl
`default_nettype wire

// ### design/conv_out_pkg.sv
// Shared constants and carrier types for the converter output side
`default_nettype none
package conv_out_pkg;
  localparam int DATA_W = 10;
  localparam int PIPE_LAT = 6;
  localparam int FIFO_DEPTH = 8;
  localparam logic [9:0] MID_LOW = 10'h1ff;
  localparam logic [9:0] MID_HIGH = 10'h200;
  localparam logic [9:0] SIGN_FLIP = 10'h200;
  localparam logic [9:0] DATA_RST = 10'h000;
  localparam int SAMPLE_W = DATA_W + 1;

  // Tagged sample travelling the pipeline
  typedef struct packed {
    logic good;
    logic [DATA_W-1:0] code;
  } sample_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_DOWN,
    ST_REFILL
  } pwr_state_t;
endpackage : conv_out_pkg
`default_nettype wire

// ### design/sample_fifo.sv
// Small synchronous FIFO holding converted samples
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // Full and empty straight from the occupancy count
  assign in_ready = (count_r != AW'(0) + (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage array, written only on accepted pushes
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and count; flush drops everything held
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else if (flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sample_fifo
`default_nettype wire

// ### tb/capture_model.sv
// Capture-side model: registers delivered words and can stall the block
`timescale 1ns/1ps
`default_nettype none
module capture_model
  import conv_out_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic stall,
  input wire logic [conv_out_pkg::DATA_W-1:0] data_out,
  input wire logic data_valid,
  input wire logic powered_down,
  output logic sink_ready,
  output logic [conv_out_pkg::DATA_W-1:0] cap_word_r,
  output logic [15:0] cap_cnt_r
);
  // Ready follows the stall request alone
  assign sink_ready = !stall;
  // rising-edge capture
  // Words seen while powered down are dropped, their meaning is undefined
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_word_r <= '0;
      cap_cnt_r <= '0;
    end else if (data_valid && sink_ready && !powered_down) begin
      cap_word_r <= data_out;
      cap_cnt_r <= cap_cnt_r + 16'h0001;
    end
  end
endmodule : capture_model
`default_nettype wire

// ### tb/adc_output_format_standby_tb.sv
// Self-checking bench for the converter output back end
`timescale 1ns/1ps
`default_nettype none
module adc_output_format_standby_tb;
  import conv_out_pkg::*;
  logic sys_clk, arst_n, low_power_hold, output_format_select, stall;
  logic sink_ready, data_valid, powered_down, overflow;
  logic [DATA_W-1:0] sample_code, data_out, cap_word;
  logic [15:0] cap_cnt;
  int failures = 0;
  int n_tests = 0;
  conv_out_ctrl dut (.sys_clk(sys_clk), .arst_n(arst_n),
    .low_power_hold(low_power_hold),
    .output_format_select(output_format_select),
    .sample_code(sample_code), .data_out(data_out),
    .data_valid(data_valid), .powered_down(powered_down),
    .sink_ready(sink_ready), .overflow(overflow));
  capture_model sink (.sys_clk(sys_clk), .arst_n(arst_n), .stall(stall),
    .data_out(data_out), .data_valid(data_valid),
    .powered_down(powered_down), .sink_ready(sink_ready),
    .cap_word_r(cap_word), .cap_cnt_r(cap_cnt));
  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task print_verdict;
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // Bounded wait for the refill after powerdown to finish
  task wait_up;
    int k;
    for (k = 0; k < 64 && powered_down !== 1'b0; k++) @(negedge sys_clk);
    if (powered_down !== 1'b0) begin
      failures++;
      print_verdict();
    end
  endtask : wait_up
  // Stream codes from base; each word is due LATENCY+2 loop steps later
  task run_stream(input logic fmt, input logic [DATA_W-1:0] base);
    int i;
    logic [DATA_W-1:0] exp;
    @(posedge sys_clk) output_format_select <= fmt;
    wait_up();
    for (i = 0; i < PIPE_LAT + 11; i++) begin
      @(posedge sys_clk) sample_code <= base + DATA_W'(i);
      @(negedge sys_clk);
      exp = base + DATA_W'(i - PIPE_LAT - 2);
      if (fmt) exp = exp ^ SIGN_FLIP;
      if (i >= PIPE_LAT + 2) begin
        chk(data_valid, 1'b1);
        chk(data_out, exp);
      end
    end
    // capture lands one edge after the word
    @(negedge sys_clk);
    chk(cap_word, exp);
  endtask : run_stream
  // Hold high: no valid words, and nothing from before the hold survives
  task run_powerdown;
    int i;
    int seen;
    logic [15:0] held_cnt;
    seen = 0;
    held_cnt = '0;
    @(posedge sys_clk) sample_code <= 10'h155;
    repeat (4) @(posedge sys_clk);
    low_power_hold <= 1'b1;
    for (i = 0; i < 12; i++) begin
      @(negedge sys_clk);
      if (i > 1) chk(powered_down, 1'b1);
      if (i > 1) chk(data_valid, 1'b0);
      if (i == 1) held_cnt = cap_cnt;
    end
    chk(cap_cnt, held_cnt);
    @(posedge sys_clk) low_power_hold <= 1'b0;
    sample_code <= 10'h0aa;
    for (i = 0; i < PIPE_LAT + 12; i++) begin
      @(negedge sys_clk);
      if (data_valid === 1'b1) begin
        seen++;
        chk(data_out, 10'h0aa);
      end
    end
    chk(16'(seen > 0), 16'h0001);
    chk(16'(seen), 16'(PIPE_LAT + 4));
    chk(cap_cnt - held_cnt, 16'(seen - 1));
  endtask : run_powerdown
  // Stall the sink until the buffer refuses, then drain
  task run_stall;
    int i;
    @(posedge sys_clk) stall <= 1'b1;
    for (i = 0; i < FIFO_DEPTH + 6; i++) @(negedge sys_clk);
    chk(data_valid, 1'b0);
    chk(overflow, 1'b1);
    @(posedge sys_clk) stall <= 1'b0;
    repeat (4) @(negedge sys_clk);
    chk(data_valid, 1'b1);
    chk(overflow, 1'b1);
  endtask : run_stall
  // Mid-run reset clears the sticky drop flag and restarts the refill
  task run_reset;
    @(posedge sys_clk) arst_n <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk({data_valid, powered_down, overflow}, 16'h0002);
    @(posedge sys_clk) arst_n <= 1'b1;
    wait_up();
    chk(data_valid, 1'b1);
    chk(data_out, 10'h0aa);
  endtask : run_reset
  initial begin
    arst_n = 1'b0;
    low_power_hold = 1'b0;
    output_format_select = 1'b0;
    stall = 1'b0;
    sample_code = 10'h000;
    repeat (20) @(posedge sys_clk);
    chk({data_out, data_valid, powered_down, overflow}, 16'h0002);
    arst_n <= 1'b1;
    run_stream(1'b0, MID_LOW - 10'h004);
    run_stream(1'b1, MID_HIGH - 10'h004);
    @(posedge sys_clk) output_format_select <= 1'b0;
    run_powerdown();
    run_stall();
    run_reset();
    print_verdict();
  end
endmodule : adc_output_format_standby_tb
`default_nettype wire
